/* design/phase_comparator_gate_drive_regs.sv */
// register bank, output filter and edge flags for phase comparator two
`timescale 1ns/1ps
`default_nettype none

module phase_comparator_gate_drive_regs
#(
   parameter int FILT_W = 8
)
(
   // clock and reset
   input  wire  logic                     mclk_i,
   input  wire  logic                     rst_n_i,
   // apb slave
   input  wire  logic                     psel_i,
   input  wire  logic                     penable_i,
   input  wire  logic                     pwrite_i,
   input  wire  logic [pcmp_pkg::ADDR_W-1:0] paddr_i,
   input  wire  logic [31:0]              pwdata_i,
   input  wire  logic [3:0]               pstrb_i,
   output logic                           pready_o,
   output logic [31:0]                    prdata_o,
   output logic                           pslverr_o,
   // analog comparator side
   input  wire  logic                     cmp_raw_i,
   input  wire  logic                     sample_strobe_i,
   output logic                           comparator_result_o,
   output logic                           comparator_enable_o,
   output logic                           window_mode_select_o,
   output logic                           comparator_irq_o,
   // clamp and pre-driver settings
   output var pcmp_pkg::clamp_cfg_t       clamp_cfg_o,
   output var pcmp_pkg::predriver_cfg_t   predriver_cfg_o
);
   import pcmp_pkg::*;

   // ****************************************
   // parameter check
   // ****************************************
   if (FILT_W < 1 || FILT_W > 8) begin : g_bad_width
      $error("FILT_W must lie between 1 and 8");
   end

   // ****************************************
   // declarations
   // ****************************************
   logic [FILT_W-1:0] filter_sample_period_r;
   logic              rising_irq_enable_r;
   logic              falling_irq_enable_r;
   logic              rising_edge_flag_r;
   logic              falling_edge_flag_r;
   logic              sample_mode_select_r;
   logic              window_mode_select_r;
   logic              output_invert_r;
   logic              comparator_enable_r;
   logic [7:0]        clamp_ctrl_r;
   logic [7:0]        io_ctrl_r;
   logic [FILT_W-1:0] sample_cnt_r;
   logic              comparator_result_r;
   logic              result_prev_r;
   logic              polar_in;
   logic              sample_tick;
   logic              result_nxt;
   logic              rise_det;
   logic              fall_det;
   logic              wr_en;
   logic              rd_en;
   logic              hit_filt;
   logic              hit_stat;
   logic              hit_mode;
   logic              hit_clamp;
   logic              hit_io;
   logic              hit_any;
   logic [7:0]        rd_byte;
   logic [7:0]        wbyte;

   // ****************************************
   // apb decode
   // ****************************************
   // indices count 32-bit words, so each register sits at four times its index
   always_comb begin
      hit_filt  = 1'b0;
      hit_stat  = 1'b0;
      hit_mode  = 1'b0;
      hit_clamp = 1'b0;
      hit_io    = 1'b0;
      if (paddr_i == ADDR_W'({FILT_PERIOD_IDX, 2'b00})) begin
         hit_filt = 1'b1;
      end else if (paddr_i == ADDR_W'({STAT_CTRL_IDX, 2'b00})) begin
         hit_stat = 1'b1;
      end else if (paddr_i == ADDR_W'({MODE_CTRL_IDX, 2'b00})) begin
         hit_mode = 1'b1;
      end else if (paddr_i == ADDR_W'({CLAMP_CTRL_IDX, 2'b00})) begin
         hit_clamp = 1'b1;
      end else if (paddr_i == ADDR_W'({IO_CTRL_IDX, 2'b00})) begin
         hit_io = 1'b1;
      end
   end

   assign hit_any   = hit_filt | hit_stat | hit_mode | hit_clamp | hit_io;
   // zero wait states: every access completes in its first access cycle
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit_any;
   // only byte lane 0 carries register data
   assign wr_en     = psel_i & penable_i & pwrite_i & pstrb_i[0];
   // read data is offered from setup on; harmless since pready is tied high
   assign rd_en     = psel_i & ~pwrite_i;
   assign wbyte     = pwdata_i[7:0];

   // ****************************************
   // filter period register
   // ****************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         filter_sample_period_r <= FILT_PERIOD_RST[FILT_W-1:0];
      end else if (wr_en && hit_filt) begin
         filter_sample_period_r <= wbyte[FILT_W-1:0];
      end
   end

   // ****************************************
   // mode control register
   // ****************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sample_mode_select_r <= MODE_CTRL_RST[SAMPLE_SEL_BIT];
         window_mode_select_r <= MODE_CTRL_RST[WINDOW_SEL_BIT];
         output_invert_r      <= MODE_CTRL_RST[INVERT_BIT];
         comparator_enable_r  <= MODE_CTRL_RST[CMP_EN_BIT];
      end else if (wr_en && hit_mode) begin
         sample_mode_select_r <= wbyte[SAMPLE_SEL_BIT];
         // sample mode wins over windowing when both are written
         window_mode_select_r <= wbyte[WINDOW_SEL_BIT] & ~wbyte[SAMPLE_SEL_BIT];
         output_invert_r      <= wbyte[INVERT_BIT];
         comparator_enable_r  <= wbyte[CMP_EN_BIT];
      end
   end

   // ****************************************
   // interrupt enables
   // ****************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rising_irq_enable_r  <= STAT_CTRL_RST[RISE_IE_BIT];
         falling_irq_enable_r <= STAT_CTRL_RST[FALL_IE_BIT];
      end else if (wr_en && hit_stat) begin
         rising_irq_enable_r  <= wbyte[RISE_IE_BIT];
         falling_irq_enable_r <= wbyte[FALL_IE_BIT];
      end
   end

   // ****************************************
   // sample timing
   // ****************************************
   assign polar_in = cmp_raw_i ^ output_invert_r;

   // counter reloads to period-1, so a sample lands every period cycles
   // a new nonzero period is picked up only once the running count reaches zero
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sample_cnt_r <= '0;
      end else if (sample_mode_select_r || filter_sample_period_r == '0) begin
         sample_cnt_r <= '0;
      end else if (sample_cnt_r == '0) begin
         sample_cnt_r <= filter_sample_period_r - FILT_W'(1);
      end else begin
         sample_cnt_r <= sample_cnt_r - FILT_W'(1);
      end
   end

   // strobe is used as is; it is taken to be synchronous to mclk_i
   always_comb begin
      if (sample_mode_select_r) begin
         sample_tick = sample_strobe_i;
      end else if (filter_sample_period_r == '0) begin
         sample_tick = 1'b1;
      end else begin
         sample_tick = (sample_cnt_r == '0);
      end
   end

   // ****************************************
   // comparator result
   // ****************************************
   // disabling still moves the result to the invert setting, which can raise a flag
   always_comb begin
      if (!comparator_enable_r) begin
         result_nxt = output_invert_r;
      end else if (sample_tick) begin
         result_nxt = polar_in;
      end else begin
         result_nxt = comparator_result_r;
      end
   end

   // the result bit is never loaded from the bus
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         comparator_result_r <= 1'b0;
         result_prev_r       <= 1'b0;
      end else begin
         comparator_result_r <= result_nxt;
         result_prev_r       <= comparator_result_r;
      end
   end

   // a single bit cannot rise and fall at once, so one flag per cycle
   assign rise_det = comparator_result_r & ~result_prev_r;
   assign fall_det = ~comparator_result_r & result_prev_r;

   // ****************************************
   // edge flags
   // ****************************************
   // set takes priority, so an edge in the clearing cycle is not lost
   // flags survive a disable; only software or reset clears them
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rising_edge_flag_r <= STAT_CTRL_RST[RISE_FLAG_BIT];
      end else if (rise_det) begin
         rising_edge_flag_r <= 1'b1;
      end else if (wr_en && hit_stat && wbyte[RISE_FLAG_BIT]) begin
         rising_edge_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         falling_edge_flag_r <= STAT_CTRL_RST[FALL_FLAG_BIT];
      end else if (fall_det) begin
         falling_edge_flag_r <= 1'b1;
      end else if (wr_en && hit_stat && wbyte[FALL_FLAG_BIT]) begin
         falling_edge_flag_r <= 1'b0;
      end
   end

   // level output, held for as long as a flag and its enable are both set
   assign comparator_irq_o = (rising_irq_enable_r & rising_edge_flag_r)
                           | (falling_irq_enable_r & falling_edge_flag_r);

   // ****************************************
   // clamp and pre-driver registers
   // ****************************************
   // reserved bits are dropped at write time so they always read zero
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clamp_ctrl_r <= CLAMP_CTRL_RST;
      end else if (wr_en && hit_clamp) begin
         clamp_ctrl_r <= wbyte & 8'hcf;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         io_ctrl_r <= IO_CTRL_RST;
      end else if (wr_en && hit_io) begin
         io_ctrl_r <= wbyte & 8'hb7;
      end
   end

   // one assignment per struct keeps each output with a single driver
   assign clamp_cfg_o = '{
      overvoltage_protect_enable: clamp_ctrl_r[7],
      overvoltage_irq_enable:     clamp_ctrl_r[6],
      clamp_trim:                 clamp_ctrl_r[3:1],
      clamp_enable:               clamp_ctrl_r[0]
   };

   // upper nibble drives the high side, lower nibble the low side
   assign predriver_cfg_o = '{
      high_side_buffer_enable:  io_ctrl_r[7],
      high_side_drive_strength: io_ctrl_r[5:4],
      // code 00 here turns the low-side buffer off in the analog block
      low_side_drive_strength:  io_ctrl_r[2:1],
      io_ctrl_bit0:             io_ctrl_r[0]
   };

   // ****************************************
   // read mux
   // ****************************************
   // only lane 0 carries data, the upper 24 bits always read zero
   always_comb begin
      rd_byte = 8'h00;
      if (hit_filt) begin
         rd_byte = 8'(filter_sample_period_r);
      end else if (hit_stat) begin
         rd_byte[RISE_IE_BIT]   = rising_irq_enable_r;
         rd_byte[FALL_IE_BIT]   = falling_irq_enable_r;
         rd_byte[RISE_FLAG_BIT] = rising_edge_flag_r;
         rd_byte[FALL_FLAG_BIT] = falling_edge_flag_r;
         rd_byte[RESULT_BIT]    = comparator_result_r;
      end else if (hit_mode) begin
         rd_byte[SAMPLE_SEL_BIT] = sample_mode_select_r;
         rd_byte[WINDOW_SEL_BIT] = window_mode_select_r;
         rd_byte[INVERT_BIT]     = output_invert_r;
         rd_byte[CMP_EN_BIT]     = comparator_enable_r;
      end else if (hit_clamp) begin
         rd_byte = clamp_ctrl_r;
      end else if (hit_io) begin
         rd_byte = io_ctrl_r;
      end
   end

   // status bits 7..5 are never assigned above and read zero
   assign prdata_o = rd_en ? {24'h000000, rd_byte} : 32'h00000000;

   // ****************************************
   // status outputs
   // ****************************************
   // straight from flip-flops so the analog side never sees a decode glitch
   assign comparator_result_o  = comparator_result_r;
   assign comparator_enable_o  = comparator_enable_r;
   assign window_mode_select_o = window_mode_select_r;

endmodule // phase_comparator_gate_drive_regs

`default_nettype wire

/* design/pcmp_pkg.sv */
// shared constants and types for the phase comparator two register bank
package pcmp_pkg;

   // ****************************************
   // register indices and address width
   // ****************************************
   localparam logic [15:0] FILT_PERIOD_IDX = 16'h002a;
   localparam logic [15:0] STAT_CTRL_IDX   = 16'h002b;
   localparam logic [15:0] MODE_CTRL_IDX   = 16'h0030;
   localparam logic [15:0] CLAMP_CTRL_IDX  = 16'h1870;
   localparam logic [15:0] IO_CTRL_IDX     = 16'h1871;
   localparam int          ADDR_W          = 16;

   // ****************************************
   // status/control field positions
   // ****************************************
   localparam int RISE_IE_BIT   = 4;
   localparam int FALL_IE_BIT   = 3;
   localparam int RISE_FLAG_BIT = 2;
   localparam int FALL_FLAG_BIT = 1;
   localparam int RESULT_BIT    = 0;

   // ****************************************
   // mode control field positions
   // ****************************************
   localparam int SAMPLE_SEL_BIT = 7;
   localparam int WINDOW_SEL_BIT = 6;
   localparam int INVERT_BIT     = 3;
   localparam int CMP_EN_BIT     = 0;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] FILT_PERIOD_RST = 8'h00;
   localparam logic [7:0] STAT_CTRL_RST   = 8'h00;
   localparam logic [7:0] MODE_CTRL_RST   = 8'h00;
   localparam logic [7:0] CLAMP_CTRL_RST  = 8'h00;
   localparam logic [7:0] IO_CTRL_RST     = 8'h00;

   // ****************************************
   // carriers for the analog-side settings
   // ****************************************
   typedef struct packed {
      logic       overvoltage_protect_enable;
      logic       overvoltage_irq_enable;
      logic [2:0] clamp_trim;
      logic       clamp_enable;
   } clamp_cfg_t;

   typedef struct packed {
      logic       high_side_buffer_enable;
      logic [1:0] high_side_drive_strength;
      logic [1:0] low_side_drive_strength;
      logic       io_ctrl_bit0;
   } predriver_cfg_t;

endpackage

/* bench/pcmp_chk.sv */
// assertion checker for the phase comparator two register bank
`timescale 1ns/1ps
`default_nettype none
module pcmp_chk (
   // clock and reset
   input wire logic                          mclk_i,
   input wire logic                          rst_n_i,
   // apb
   input wire logic                          psel_i,
   input wire logic                          penable_i,
   input wire logic                          pwrite_i,
   input wire logic [pcmp_pkg::ADDR_W-1:0]   paddr_i,
   input wire logic [31:0]                   pwdata_i,
   input wire logic [3:0]                    pstrb_i,
   input wire logic [31:0]                   prdata_o,
   // comparator and settings
   input wire logic                          comparator_result_o,
   input wire logic                          comparator_enable_o,
   input wire logic                          window_mode_select_o,
   input wire logic                          comparator_irq_o,
   input wire pcmp_pkg::clamp_cfg_t          clamp_cfg_o,
   input wire pcmp_pkg::predriver_cfg_t      predriver_cfg_o
);
   import pcmp_pkg::*;
   logic acc, wr, rd_st, rd_cfg, wr_st, wr_md, wr_cl, wr_io;
   assign acc    = psel_i & penable_i;
   assign wr     = acc & pwrite_i & pstrb_i[0];
   assign rd_st  = acc & !pwrite_i & (paddr_i == {STAT_CTRL_IDX[13:0], 2'h0});
   // clamp and io control share one aligned pair, bit 2 tells them apart
   assign rd_cfg = acc & !pwrite_i & (paddr_i[15:3] == CLAMP_CTRL_IDX[13:1]);
   assign wr_st  = wr & (paddr_i == {STAT_CTRL_IDX[13:0], 2'h0});
   assign wr_md  = wr & (paddr_i == {MODE_CTRL_IDX[13:0], 2'h0});
   assign wr_cl  = wr & (paddr_i == {CLAMP_CTRL_IDX[13:0], 2'h0});
   assign wr_io  = wr & (paddr_i == {IO_CTRL_IDX[13:0], 2'h0});
   default clocking dc @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   property p_irq_src;
      rd_st |-> comparator_irq_o == ((prdata_o[4] & prdata_o[2]) | (prdata_o[3] & prdata_o[1]));
   endproperty
   a_irq_src: assert property (p_irq_src) else $error("irq disagrees with status");
   property p_stat_rsvd;
      rd_st |-> prdata_o[31:5] == 27'h0;
   endproperty
   a_stat_rsvd: assert property (p_stat_rsvd) else $error("status spare bits set");
   property p_rd_result;
      rd_st |-> prdata_o[0] == comparator_result_o;
   endproperty
   a_rd_result: assert property (p_rd_result) else $error("result bit mismatch");
   property p_cfg_rsvd;
      rd_cfg |-> prdata_o[31:8] == 24'h0 &&
         (paddr_i[2] ? {prdata_o[6], prdata_o[3]} == 2'h0 : prdata_o[5:4] == 2'h0);
   endproperty
   a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config spare bits set");
   property p_clamp_wr;
      wr_cl |=> clamp_cfg_o == {$past(pwdata_i[7:6]), $past(pwdata_i[3:1]), $past(pwdata_i[0])};
   endproperty
   a_clamp_wr: assert property (p_clamp_wr) else $error("clamp fields");
   property p_io_wr;
      wr_io |=> predriver_cfg_o == {$past(pwdata_i[7]), $past(pwdata_i[5:4]), $past(pwdata_i[2:0])};
   endproperty
   a_io_wr: assert property (p_io_wr) else $error("predriver fields");
   property p_both_modes;
      wr_md && pwdata_i[7:6] == 2'h3 |=> !window_mode_select_o;
   endproperty
   a_both_modes: assert property (p_both_modes) else $error("window mode kept");
   property p_irq_cause;
      $rose(comparator_irq_o) |->
         $past(comparator_result_o) != $past(comparator_result_o, 2) || $past(wr_st);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without edge");
   property p_result_hold;
      $changed(comparator_result_o) |->
         $past(comparator_enable_o) || $past(wr_md) || $past(wr_md, 2);
   endproperty
   a_result_hold: assert property (p_result_hold) else $error("result moved");
   property p_set_wins;
      wr_st && pwdata_i[4] && pwdata_i[2] && comparator_result_o &&
         !$past(comparator_result_o) |=> comparator_irq_o;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("edge lost to clear");
endmodule // pcmp_chk
bind phase_comparator_gate_drive_regs pcmp_chk u_chk (.mclk_i, .rst_n_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .comparator_result_o,
   .comparator_enable_o, .window_mode_select_o, .comparator_irq_o, .clamp_cfg_o,
   .predriver_cfg_o);
`default_nettype wire

/* bench/cmp_front_model.sv */
// behavioural analog comparator and sample strobe source
`timescale 1ns/1ps
`default_nettype none
module cmp_front_model (
   // clock
   input  wire logic clk_i,
   // bench control
   input  wire logic level_i,
   input  wire logic toggle_i,
   input  wire logic strobe_i,
   // comparator side
   output var logic  cmp_raw_o,
   output var logic  sample_strobe_o
);
   initial begin
      cmp_raw_o = 1'h0;
      sample_strobe_o = 1'h0;
   end
   // toggling every cycle makes each filter tick see the opposite level when the filter period is odd or zero
   always @(posedge clk_i) begin
      cmp_raw_o <= toggle_i ? !cmp_raw_o : level_i;
      sample_strobe_o <= strobe_i;
   end
endmodule // cmp_front_model
`default_nettype wire

/* bench/tb_top.sv */
// self-checking testbench for the phase comparator two register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pcmp_pkg::*;
   logic           clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [15:0]    paddr = 16'h0;
   logic [31:0]    pwdata = 32'h0;
   logic [3:0]     pstrb = 4'hf;
   logic           lvl = 1'h0, tgl = 1'h0, stb = 1'h0;
   logic           pready, pslverr, raw, s_stb, res, en, win, irq, rerr;
   logic [31:0]    prdata, rdv;
   clamp_cfg_t     ccfg;
   predriver_cfg_t pcfg;
   int             error_cnt = 0, checks = 0;
   time            t0;
   always #2 clk = ~clk;
   phase_comparator_gate_drive_regs u_dut (.mclk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
      .cmp_raw_i(raw), .sample_strobe_i(s_stb), .comparator_result_o(res),
      .comparator_enable_o(en), .window_mode_select_o(win), .comparator_irq_o(irq),
      .clamp_cfg_o(ccfg), .predriver_cfg_o(pcfg));
   cmp_front_model u_front (.clk_i(clk), .level_i(lvl), .toggle_i(tgl), .strobe_i(stb),
      .cmp_raw_o(raw), .sample_strobe_o(s_stb));
   // ****************************************
   // bus and check tasks
   // ****************************************
   task end_sim;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // no wait-state count assumed; the watchdog ends a hang
   task apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {idx[13:0], 2'h0};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rdv = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(negedge clk);
   endtask
   task rd(input logic [15:0] idx, input logic [31:0] exp);
      apb(1'h0, idx, 8'h0);
      chk(rdv, exp);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      rd(FILT_PERIOD_IDX, {24'h0, FILT_PERIOD_RST});
      rd(STAT_CTRL_IDX, {24'h0, STAT_CTRL_RST});
      rd(MODE_CTRL_IDX, {24'h0, MODE_CTRL_RST});
      rd(CLAMP_CTRL_IDX, {24'h0, CLAMP_CTRL_RST});
      rd(IO_CTRL_IDX, {24'h0, IO_CTRL_RST});
      apb(1'h1, CLAMP_CTRL_IDX, 8'hff);
      rd(CLAMP_CTRL_IDX, 32'hcf);
      chk({26'h0, ccfg}, 32'h3f);
      // lane 0 strobe low: the write must be dropped
      @(posedge clk) pstrb <= 4'he;
      apb(1'h1, CLAMP_CTRL_IDX, 8'h00);
      @(posedge clk) pstrb <= 4'hf;
      rd(CLAMP_CTRL_IDX, 32'hcf);
      apb(1'h1, IO_CTRL_IDX, 8'hff);
      rd(IO_CTRL_IDX, 32'hb7);
      chk({26'h0, pcfg}, 32'h3f);
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, IO_CTRL_IDX, {2'h0, i[1:0], 1'h0, i[1:0], 1'h0});
         chk({26'h0, pcfg}, {26'h0, 1'h0, i[1:0], i[1:0], 1'h0});
      end
      // unmapped place is refused and reads zero
      apb(1'h0, 16'h0031, 8'h0);
      chk({rdv[30:0], rerr}, 32'h1);
      apb(1'h1, FILT_PERIOD_IDX, 8'h03);
      apb(1'h1, MODE_CTRL_IDX, 8'h40);
      chk({30'h0, win, en}, 32'h2);
      apb(1'h1, MODE_CTRL_IDX, 8'hc1);
      rd(MODE_CTRL_IDX, 32'h81);
      chk({30'h0, win, en}, 32'h1);
      @(posedge clk) lvl <= 1'h1;
      repeat (8) @(negedge clk);
      chk({31'h0, res}, 32'h0);
      @(posedge clk) stb <= 1'h1;
      @(posedge clk) stb <= 1'h0;
      repeat (3) @(negedge clk);
      chk({31'h0, res}, 32'h1);
      rd(STAT_CTRL_IDX, 32'h05);
      apb(1'h1, STAT_CTRL_IDX, 8'h10);
      rd(STAT_CTRL_IDX, 32'h15);
      chk({31'h0, irq}, 32'h1);
      apb(1'h1, STAT_CTRL_IDX, 8'h14);
      rd(STAT_CTRL_IDX, 32'h11);
      apb(1'h1, MODE_CTRL_IDX, 8'h01);
      @(posedge clk) lvl <= 1'h0;
      repeat (8) @(posedge clk);
      rd(STAT_CTRL_IDX, 32'h12);
      apb(1'h1, STAT_CTRL_IDX, 8'h08);
      chk({31'h0, irq}, 32'h1);
      apb(1'h1, STAT_CTRL_IDX, 8'h02);
      rd(STAT_CTRL_IDX, 32'h00);
      // alternate level each cycle so each tick flips the result
      @(posedge clk) tgl <= 1'h1;
      repeat (2) @(res);
      t0 = $time;
      @(res);
      chk(32'(($time - t0) / 4), 32'h3);
      apb(1'h1, FILT_PERIOD_IDX, 8'h00);
      repeat (4) @(res);
      t0 = $time;
      @(res);
      chk(32'(($time - t0) / 4), 32'h1);
      @(posedge clk) tgl <= 1'h0;
      repeat (3) @(posedge clk);
      apb(1'h1, STAT_CTRL_IDX, 8'h06);
      // the rise lands on the very edge that writes its clear
      @(posedge clk) lvl <= 1'h1;
      apb(1'h1, STAT_CTRL_IDX, 8'h14);
      rd(STAT_CTRL_IDX, 32'h15);
      @(posedge clk) lvl <= 1'h0;
      apb(1'h1, MODE_CTRL_IDX, 8'h08);
      @(negedge clk);
      chk({31'h0, res}, 32'h1);
      apb(1'h1, STAT_CTRL_IDX, 8'h06);
      rd(STAT_CTRL_IDX, 32'h01);
      @(posedge clk) lvl <= 1'h1;
      apb(1'h1, MODE_CTRL_IDX, 8'h09);
      repeat (3) @(posedge clk);
      rd(STAT_CTRL_IDX, 32'h02);
      apb(1'h1, STAT_CTRL_IDX, 8'h01);
      rd(STAT_CTRL_IDX, 32'h02);
      end_sim;
   end
   initial begin
      #40000;
      error_cnt++;
      end_sim;
   end
endmodule // tb_top
`default_nettype wire
